/* File: ppa_top.sv */
// priority shutdown and pair power allocation logic of a four-channel sourcing controller
//
// Operation
// R1: code at or below channel level turns off
// R2: level 101 off by all codes but 111
// R3: level 111 off by any code
// R4: equal levels shut down together
// R5: shutdown keeps running fault cool-down timers
// R6: clear channel event and status bits
// R7: load channel policing registers with ff
// R8: clear channel voltage and current measurements
// R9: clear requested class and detection results
// R10: clear assigned class, resistance, autoclass values
// R11: no code history, act on each code
// R12: host sends new code for more channels
// R13: allocation code selects pair power limit
// R14: pair fields in bits 2..0 and 6..4
// R15: allocation taken at power-on, later ignored
// R16: 4 W powers only class 1
// R17: 7 W powers classes 1 and 2
// R18: allocation at command 29h, resets zero
// R19: shutdown only while priority scheme enabled
// R20: code above level leaves channel alone; level 101 is still turned off by code 110
// R21: priority bytes at 27h and 28h, zero reset
`timescale 1ns/1ps
module ppa_top (
  input  wire logic        clk,
  input  wire logic        reset,
  // command port
  input  wire logic        cmd_valid,
  input  wire logic        cmd_we,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [7:0]  cmd_wdata,
  output logic      [7:0]  cmd_rdata,
  output logic             cmd_rvalid,
  // shutdown pins
  input  wire logic        shutdown_strobe,
  input  wire logic [2:0]  fast_shutdown_code,
  input  wire logic        priority_scheme_enable,
  // channel reset or off-mode request from the channel logic
  input  wire logic [3:0]  chan_reset_req,
  // power-on request
  input  wire logic        power_on_cmd,
  input  wire logic [1:0]  pwr_on_chan,
  input  wire logic [2:0]  pwr_on_class,
  // effects
  output logic      [3:0]  chan_off,
  output logic      [3:0]  event_status_clear,
  output logic      [3:0]  meas_clear,
  output logic      [3:0]  class_clear,
  output logic      [3:0]  policing_load,
  output logic      [7:0]  policing_value,
  output logic      [3:0]  cooldown_cancel,
  output logic      [3:0]  power_grant,
  output logic      [3:0]  insufficient_power_fault,
  output logic      [11:0] pair_power_limit_sel
);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0] prio12_q;
  logic [7:0] prio34_q;
  logic [7:0] alloc_q;
  logic [7:0] cmd_rdata_q;
  logic       cmd_rvalid_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prio12_q <= ppa_pkg::PRIO_RST; // R21
      prio34_q <= ppa_pkg::PRIO_RST; // R21
      alloc_q  <= ppa_pkg::ALLOC_RST; // R18
    end else if (cmd_valid && cmd_we) begin
      case (cmd_code)
        ppa_pkg::CMD_PRIO_12: prio12_q <= cmd_wdata; // R21
        ppa_pkg::CMD_PRIO_34: prio34_q <= cmd_wdata; // R21
        ppa_pkg::CMD_ALLOC:   alloc_q  <= cmd_wdata; // R18 R14
        default: ;
      endcase
    end
  end

  // reads answer one cycle later; unknown codes read as zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmd_rdata_q  <= 8'h00;
      cmd_rvalid_q <= 1'b0;
    end else begin
      cmd_rvalid_q <= cmd_valid && !cmd_we;
      if (cmd_valid && !cmd_we) begin
        case (cmd_code)
          ppa_pkg::CMD_PRIO_12: cmd_rdata_q <= prio12_q;
          ppa_pkg::CMD_PRIO_34: cmd_rdata_q <= prio34_q;
          ppa_pkg::CMD_ALLOC:   cmd_rdata_q <= alloc_q; // R18
          default:              cmd_rdata_q <= 8'h00;
        endcase
      end
    end
  end

  assign cmd_rdata  = cmd_rdata_q;
  assign cmd_rvalid = cmd_rvalid_q;

  ////////////////////////////////////////////////////////////////////////////
  // shutdown code reception

  logic [3:0] pin_sync;
  logic       strobe_prev_q;
  logic       sd_evt;
  logic [2:0] sd_code;

  ppa_sync #(
    .W (4)
  ) u_sync (
    .clk   (clk),
    .reset (reset),
    .d     ({shutdown_strobe, fast_shutdown_code}),
    .q     (pin_sync)
  );

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      strobe_prev_q <= 1'b0;
    end else begin
      strobe_prev_q <= pin_sync[3];
    end
  end

  // each strobe rise is judged on its own, nothing of earlier codes is kept
  assign sd_evt  = pin_sync[3] && !strobe_prev_q; // R11
  assign sd_code = pin_sync[2:0];

  logic [3:0][2:0] level_w;
  logic [3:0]      sd_hit;

  assign level_w[0] = prio12_q[ppa_pkg::FLD_LO_LSB +: ppa_pkg::FIELD_W];
  assign level_w[1] = prio12_q[ppa_pkg::FLD_HI_LSB +: ppa_pkg::FIELD_W];
  assign level_w[2] = prio34_q[ppa_pkg::FLD_LO_LSB +: ppa_pkg::FIELD_W];
  assign level_w[3] = prio34_q[ppa_pkg::FLD_HI_LSB +: ppa_pkg::FIELD_W];

  // every channel is compared in parallel, so equal levels drop together
  for (genvar ch = 0; ch < ppa_pkg::NUM_CH; ch++) begin : g_cmp
    ppa_chan_cmp u_cmp (
      .enable                 (priority_scheme_enable), // R19
      .evt                    (sd_evt),
      .code                   (sd_code),
      .channel_priority_level (level_w[ch]),
      .hit                    (sd_hit[ch]) // R4
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // turn-off effects

  logic [3:0] chan_off_q;
  logic [3:0] clear_q;
  logic [3:0] cooldown_cancel_q;
  logic [7:0] policing_value_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      chan_off_q        <= 4'h0;
      clear_q           <= 4'h0;
      cooldown_cancel_q <= 4'h0;
    end else begin
      chan_off_q        <= sd_hit;
      clear_q           <= sd_hit | chan_reset_req; // R6 R7 R8 R9 R10
      // only a true channel reset stops a running cool-down
      cooldown_cancel_q <= chan_reset_req & ~sd_hit; // R5
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      policing_value_q <= ppa_pkg::POLICE_OFF_VAL;
    end else begin
      policing_value_q <= ppa_pkg::POLICE_OFF_VAL; // R7
    end
  end

  assign chan_off           = chan_off_q;
  assign event_status_clear = clear_q; // R6
  assign policing_load      = clear_q; // R7
  assign meas_clear         = clear_q; // R8
  assign class_clear        = clear_q; // R9 R10
  assign cooldown_cancel    = cooldown_cancel_q;
  assign policing_value     = policing_value_q;

  ////////////////////////////////////////////////////////////////////////////
  // power allocation

  function automatic logic class_ok(input logic [2:0] alloc, input logic [2:0] cls);
    logic ok;
    ok = 1'b0;
    case (alloc)
      ppa_pkg::ALLOC_4W:   ok = (cls == ppa_pkg::CLS_1); // R16
      ppa_pkg::ALLOC_7W:   ok = (cls == ppa_pkg::CLS_1) || (cls == ppa_pkg::CLS_2); // R17
      ppa_pkg::ALLOC_15W4: ok = (cls <= ppa_pkg::CLS_MAX_15); // R13
      ppa_pkg::ALLOC_30W:  ok = (cls <= ppa_pkg::CLS_MAX_30); // R13
      default:             ok = 1'b0;
    endcase
    return ok;
  endfunction

  logic [2:0]      pair_alloc_w;
  logic            pwr_ok_w;
  logic [3:0]      grant_q;
  logic [3:0]      fault_q;
  logic [3:0][2:0] limit_q;

  // both channels of a pair read the same field
  assign pair_alloc_w = pwr_on_chan[1] ? alloc_q[ppa_pkg::FLD_HI_LSB +: ppa_pkg::FIELD_W]
                                       : alloc_q[ppa_pkg::FLD_LO_LSB +: ppa_pkg::FIELD_W]; // R14
  assign pwr_ok_w     = class_ok(pair_alloc_w, pwr_on_class);

  // a power-on that meets a shutdown of the same channel is dropped
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      grant_q <= 4'h0;
      fault_q <= 4'h0;
    end else begin
      grant_q <= 4'h0;
      fault_q <= 4'h0;
      if (power_on_cmd && !sd_hit[pwr_on_chan]) begin
        if (pwr_ok_w) begin
          grant_q[pwr_on_chan] <= 1'b1;
        end else begin
          fault_q[pwr_on_chan] <= 1'b1; // R16 R17
        end
      end
    end
  end

  // limit is frozen at power-on so later allocation writes do not touch it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      limit_q <= '0;
    end else if (power_on_cmd && !sd_hit[pwr_on_chan] && pwr_ok_w) begin
      limit_q[pwr_on_chan] <= pair_alloc_w; // R15
    end
  end

  assign power_grant              = grant_q;
  assign insufficient_power_fault = fault_q;
  assign pair_power_limit_sel     = limit_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_SD_LE_OFF: assert property ( // R1
    sd_evt && priority_scheme_enable && (sd_code <= level_w[0]) |=> chan_off[0] && clear_q[0])
    else $error("channel 0 not turned off by code at or below its level");

  AST_SD_GT_KEEP: assert property ( // R20
    sd_evt && (sd_code > level_w[0]) && (level_w[0] != 3'h5) |=> !chan_off[0])
    else $error("channel 0 turned off by code above its level");

  AST_LEVEL5: assert property ( // R2
    sd_evt && priority_scheme_enable && (level_w[1] == 3'h5) |=> (chan_off[1] == ($past(sd_code) != 3'h7)))
    else $error("level 101 channel answered wrongly to code");

  AST_LEVEL7: assert property ( // R3
    sd_evt && priority_scheme_enable && (level_w[2] == 3'h7) |=> chan_off[2])
    else $error("lowest level channel survived a code");

  AST_SAME_LEVEL: assert property ( // R4
    sd_evt && (level_w[0] == level_w[3]) |=> (chan_off[0] == chan_off[3]))
    else $error("channels of equal level did not drop together");

  AST_NO_ENABLE: assert property ( // R19
    !priority_scheme_enable ##1 !priority_scheme_enable |-> chan_off == 4'h0)
    else $error("shutdown acted while scheme disabled");

  AST_COOLDOWN: assert property ( // R5
    chan_off[0] |-> !cooldown_cancel[0])
    else $error("shutdown cancelled a cool-down");

  AST_CLEARS: assert property ( // R6 R8 R9 R10
    chan_off != 4'h0 |-> ((event_status_clear & meas_clear & class_clear & chan_off) == chan_off))
    else $error("shutdown did not clear channel state");

  AST_POLICE: assert property ( // R7
    policing_load != 4'h0 |-> policing_value == 8'hff)
    else $error("policing not loaded with ff");

  AST_4W: assert property ( // R16
    power_on_cmd && (pwr_on_chan == 2'h0) && !sd_hit[0] && (alloc_q[2:0] == 3'h1)
      |=> (power_grant[0] == ($past(pwr_on_class) == 3'h1)) && (insufficient_power_fault[0] != power_grant[0]))
    else $error("4 W allocation decision wrong");

  AST_7W: assert property ( // R17
    power_on_cmd && (pwr_on_chan == 2'h2) && !sd_hit[2] && (alloc_q[6:4] == 3'h2) && (pwr_on_class >= 3'h3)
      |=> insufficient_power_fault[2] && !power_grant[2])
    else $error("7 W allocation powered class 3 or above");

  AST_LATCH: assert property ( // R15 R13
    power_grant[1] |-> pair_power_limit_sel[5:3] == $past(alloc_q[2:0]))
    else $error("granted limit not taken from pair field");

  AST_READBACK: assert property ( // R18
    cmd_valid && !cmd_we && (cmd_code == 8'h29) ##1 !(cmd_valid && cmd_we)
      |-> cmd_rvalid && (cmd_rdata == alloc_q))
    else $error("allocation read back wrong");

  AST_RVALID: assert property ( // R18
    cmd_valid && !cmd_we |=> cmd_rvalid)
    else $error("read request got no answer");

  AST_PRIO_READ: assert property ( // R21
    cmd_valid && !cmd_we && (cmd_code == 8'h27)
      |=> cmd_rvalid && (cmd_rdata == $past(prio12_q)))
    else $error("priority byte read back wrong");

  AST_COOL_ALL: assert property ( // R5
    (chan_off & cooldown_cancel) == 4'h0)
    else $error("shutdown of a channel cancelled its cool-down");

  AST_30W: assert property ( // R13
    power_on_cmd && (pwr_on_chan == 2'h3) && !sd_hit[3] && (alloc_q[6:4] == 3'h3) && (pwr_on_class <= 3'h4)
      |=> power_grant[3] && !insufficient_power_fault[3])
    else $error("30 W allocation refused a class 0 to 4 device");

  AST_RSVD_ALLOC: assert property ( // R13
    power_on_cmd && !sd_hit[pwr_on_chan] && pair_alloc_w[2]
      |=> (power_grant == 4'h0) && (insufficient_power_fault != 4'h0))
    else $error("reserved allocation code powered a channel");

  AST_ONE_EVT: assert property ( // R11
    sd_evt |=> !sd_evt)
    else $error("one strobe rise gave two shutdown events");

  AST_LEVEL0: assert property ( // R1
    sd_evt && priority_scheme_enable && (level_w[3] == 3'h0)
      |=> (chan_off[3] == ($past(sd_code) == 3'h0)))
    else $error("highest level channel answered wrongly to code");

  AST_7W_OK: assert property ( // R17
    power_on_cmd && (pwr_on_chan == 2'h1) && !sd_hit[1] && (alloc_q[2:0] == 3'h2)
      && ((pwr_on_class == 3'h1) || (pwr_on_class == 3'h2))
      |=> power_grant[1])
    else $error("7 W allocation refused a class 1 or 2 device");

  COV_MULTI_OFF: cover property (chan_off == 4'hf);
  COV_FAULT:     cover property (insufficient_power_fault != 4'h0);
  COV_GRANT_30W: cover property (power_grant[3] && pair_power_limit_sel[11:9] == 3'h3);
  COV_SD_DISABLED: cover property (sd_evt && !priority_scheme_enable);
  COV_RESET_CANCEL: cover property (cooldown_cancel != 4'h0);

endmodule

/* File: ppa_pkg.sv */
// shared constants for the priority shutdown and pair power allocation block
package ppa_pkg;

  localparam int NUM_CH  = 4;
  localparam int FIELD_W = 3;

  // command codes of the register port
  localparam logic [7:0] CMD_PRIO_12 = 8'h27;
  localparam logic [7:0] CMD_PRIO_34 = 8'h28;
  localparam logic [7:0] CMD_ALLOC   = 8'h29;

  // reset values
  localparam logic [7:0] PRIO_RST  = 8'h00;
  localparam logic [7:0] ALLOC_RST = 8'h00;

  // field positions: low channel or pair in bits 2..0, high one in bits 6..4
  localparam int FLD_LO_LSB = 0;
  localparam int FLD_HI_LSB = 4;

  // allocation codes
  localparam logic [2:0] ALLOC_15W4 = 3'h0;
  localparam logic [2:0] ALLOC_4W   = 3'h1;
  localparam logic [2:0] ALLOC_7W   = 3'h2;
  localparam logic [2:0] ALLOC_30W  = 3'h3;

  // powered-device classes
  localparam logic [2:0] CLS_1      = 3'h1;
  localparam logic [2:0] CLS_2      = 3'h2;
  localparam logic [2:0] CLS_MAX_15 = 3'h3;
  localparam logic [2:0] CLS_MAX_30 = 3'h4;

  // policing value loaded when a channel is shut down
  localparam logic [7:0] POLICE_OFF_VAL = 8'hff;

endpackage

/* File: ppa_sync.sv */
// three-stage synchroniser for pin inputs, output moves when stages two and three agree
`timescale 1ns/1ps
module ppa_sync #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // per bit: a change is taken only once it has held for two samples
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          q[i] <= s3_q[i];
        end
      end
    end
  end

endmodule

/* File: ppa_chan_cmp.sv */
// per-channel shutdown decision against the channel priority level
`timescale 1ns/1ps
module ppa_chan_cmp (
  input  wire logic       enable,
  input  wire logic       evt,
  input  wire logic [2:0] code,
  input  wire logic [2:0] channel_priority_level,
  output logic            hit
);

  // larger level means lower rank; a code at or below the level turns it off
  // level 101 is the one exception: every code but 111 turns it off
  assign hit = evt & enable & ((code <= channel_priority_level) |
                               ((channel_priority_level == 3'h5) & (code != 3'h7))); // R1 R2 R3 R20

endmodule

/* File: ppa_host_model.sv */
// host-side model that drives the fast shutdown pins one code at a time
`timescale 1ns/1ps
module ppa_host_model (
  input  wire logic       clk,
  input  wire logic       send,
  input  wire logic [2:0] code,
  output logic            shutdown_strobe,
  output logic      [2:0] fast_shutdown_code,
  output logic            busy
);
  initial begin
    shutdown_strobe = 1'b0;
    fast_shutdown_code = 3'h0;
    busy = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // a request is sampled on the rising edge, so the pins never move on the sampling edge
  always begin
    @(posedge clk);
    if (send) begin
      busy = 1'b1;
      @(negedge clk);
      fast_shutdown_code = code;
      // code settles well ahead of the strobe so the synchroniser sees a clean value
      repeat (3) @(negedge clk);
      shutdown_strobe = 1'b1;
      repeat (4) @(negedge clk);
      shutdown_strobe = 1'b0;
      // strobe stays low long enough for the next rise to count as a new code
      repeat (4) @(negedge clk);
      @(posedge clk);
      busy = 1'b0;
    end
  end
endmodule

/* File: testbench.sv */
// self-checking bench for the priority shutdown and pair power allocation block
`timescale 1ns/1ps
module testbench;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        cmd_valid, cmd_we, priority_scheme_enable, power_on_cmd, sd_send, busy;
  logic [7:0]  cmd_code, cmd_wdata, cmd_rdata, policing_value;
  logic        cmd_rvalid, shutdown_strobe;
  logic [2:0]  fast_shutdown_code, sd_code, pwr_on_class;
  logic [1:0]  pwr_on_chan;
  logic [3:0]  chan_reset_req, chan_off, event_status_clear, meas_clear, class_clear;
  logic [3:0]  policing_load, cooldown_cancel, power_grant, insufficient_power_fault;
  logic [11:0] pair_power_limit_sel;
  logic [2:0]  lvl [4];
  logic [31:0] rng;
  int          miscompares = 0;
  int          checks_done = 0;

  always #50 clk = ~clk;

  ppa_host_model ppa_host_model_inst (.clk(clk), .send(sd_send), .code(sd_code),
    .shutdown_strobe(shutdown_strobe), .fast_shutdown_code(fast_shutdown_code), .busy(busy));

  ppa_top ppa_top_inst (.clk(clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_we(cmd_we),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
    .shutdown_strobe(shutdown_strobe), .fast_shutdown_code(fast_shutdown_code),
    .priority_scheme_enable(priority_scheme_enable), .chan_reset_req(chan_reset_req),
    .power_on_cmd(power_on_cmd), .pwr_on_chan(pwr_on_chan), .pwr_on_class(pwr_on_class),
    .chan_off(chan_off), .event_status_clear(event_status_clear), .meas_clear(meas_clear),
    .class_clear(class_clear), .policing_load(policing_load), .policing_value(policing_value),
    .cooldown_cancel(cooldown_cancel), .power_grant(power_grant),
    .insufficient_power_fault(insufficient_power_fault), .pair_power_limit_sel(pair_power_limit_sel));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] nxt();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  task automatic wrap_up();
    if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic reg_wr(input logic [7:0] c, input logic [7:0] d);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_we = 1'b1;
    cmd_code = c;
    cmd_wdata = d;
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] c, input logic [7:0] e);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_we = 1'b0;
    cmd_code = c;
    @(negedge clk);
    cmd_valid = 1'b0;
    chk("cmd_rvalid", 12'h001, 12'(cmd_rvalid));
    chk("cmd_rdata", 12'(e), 12'(cmd_rdata));
  endtask

  // one code through the host model; pulses are gathered over the whole frame
  task automatic shut(input logic [2:0] c, input logic en);
    logic [3:0] off_a, clr_a, cc_a, ex;
    off_a = 4'h0;
    clr_a = 4'h0;
    cc_a = 4'h0;
    ex = 4'h0;
    for (int i = 0; i < 4; i++) if (en && (c <= lvl[i] || (lvl[i] == 3'h5 && c != 3'h7))) ex[i] = 1'b1;
    @(negedge clk);
    priority_scheme_enable = en;
    sd_code = c;
    sd_send = 1'b1;
    @(negedge clk);
    sd_send = 1'b0;
    for (int k = 0; k < 40; k++) begin
      @(negedge clk);
      off_a |= chan_off;
      clr_a |= event_status_clear & meas_clear & class_clear & policing_load;
      cc_a |= cooldown_cancel;
      if (!busy) break;
    end
    if (busy) begin
      miscompares++;
      wrap_up();
    end
    chk("chan_off", 12'(ex), 12'(off_a));
    chk("clear_pulses", 12'(ex), 12'(clr_a));
    chk("cooldown_cancel", 12'h000, 12'(cc_a));
  endtask

  task automatic pwr(input logic [2:0] a, input logic [2:0] cl);
    logic [31:0] r;
    logic [1:0]  ch;
    logic        ok;
    logic [7:0]  w;
    r = nxt();
    ch = r[1:0];
    w = ch[1] ? {r[8], a, r[9], r[6:4]} : {r[8], r[6:4], r[9], a};
    reg_wr(ppa_pkg::CMD_ALLOC, w);
    reg_rd(ppa_pkg::CMD_ALLOC, w);
    ok = (a == 3'h0 && cl <= 3'h3) || (a == 3'h1 && cl == 3'h1) || (a == 3'h2 && (cl == 3'h1 || cl == 3'h2))
      || (a == 3'h3 && cl <= 3'h4);
    @(negedge clk);
    power_on_cmd = 1'b1;
    pwr_on_chan = ch;
    pwr_on_class = cl;
    @(negedge clk);
    power_on_cmd = 1'b0;
    chk("power_grant", 12'(ok) << ch, 12'(power_grant));
    chk("insufficient_power_fault", 12'(!ok) << ch, 12'(insufficient_power_fault));
    if (ok) chk("pair_power_limit_sel", 12'(a), 12'(pair_power_limit_sel[ch*3 +: 3]));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] x;
    logic [3:0]  clr_a, cc_a;
    cmd_valid = 1'b0;
    cmd_we = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 8'h00;
    priority_scheme_enable = 1'b0;
    chan_reset_req = 4'h0;
    power_on_cmd = 1'b0;
    pwr_on_chan = 2'h0;
    pwr_on_class = 3'h0;
    sd_send = 1'b0;
    sd_code = 3'h0;
    rng = 32'd79608;
    repeat (12) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    chk("policing_value", 12'h0ff, 12'(policing_value));
    reg_rd(ppa_pkg::CMD_PRIO_12, 8'h00);
    reg_rd(ppa_pkg::CMD_PRIO_34, 8'h00);
    reg_rd(ppa_pkg::CMD_ALLOC, 8'h00);
    reg_wr(8'h2c, 8'h5a);
    reg_rd(8'h2c, 8'h00);
    // first rounds put every channel on one shared level to catch grouped shutdown
    for (int rd = 0; rd < 5; rd++) begin
      x = nxt();
      if (rd == 0) x = 32'h0000_5555;
      if (rd == 1) x = 32'h0000_7777;
      reg_wr(ppa_pkg::CMD_PRIO_12, x[7:0]);
      reg_wr(ppa_pkg::CMD_PRIO_34, x[15:8]);
      reg_rd(ppa_pkg::CMD_PRIO_12, x[7:0]);
      reg_rd(ppa_pkg::CMD_PRIO_34, x[15:8]);
      lvl[0] = x[2:0];
      lvl[1] = x[6:4];
      lvl[2] = x[10:8];
      lvl[3] = x[14:12];
      for (int c = 0; c < 8; c++) shut(3'(c), 1'b1);
    end
    shut(3'h0, 1'b0);
    clr_a = 4'h0;
    cc_a = 4'h0;
    @(negedge clk);
    chan_reset_req = 4'h5;
    for (int k = 0; k < 4; k++) begin
      @(negedge clk);
      chan_reset_req = 4'h0;
      clr_a |= event_status_clear & meas_clear & class_clear & policing_load;
      cc_a |= cooldown_cancel;
    end
    chk("reset_clears", 12'h005, 12'(clr_a));
    chk("reset_cooldown_cancel", 12'h005, 12'(cc_a));
    for (int a = 0; a < 8; a++) begin
      for (int cl = 0; cl < 5; cl++) pwr(3'(a), 3'(cl));
    end
    wrap_up();
  end
endmodule
